// ### hdl/tls_consts.svh
// Offsets, field positions, reset values and timing constants of the time-of-day unit
`ifndef TLS_CONSTS_SVH
`define TLS_CONSTS_SVH
`define TLS_OFS_PDOM   12'h000
`define TLS_OFS_IST    12'h004
`define TLS_OFS_IMSK   12'h008
`define TLS_OFS_ADJ0   12'h010
`define TLS_CTL_PAGE   4'h1
`define TLS_R_CTRL     3'h0
`define TLS_R_SECH     3'h1
`define TLS_R_SECL     3'h2
`define TLS_R_NSEC     3'h3
`define TLS_R_NSF      3'h4
`define TLS_R_WFH      3'h5
`define TLS_R_WFL      3'h6
`define TLS_F_ACT      1:0
`define TLS_F_SYNC     2
`define TLS_F_INV      3
`define TLS_F_DOM      5:4
`define TLS_F_ARM      8
`define TLS_F_ADJ_EN   31
`define TLS_F_ADJ_DN   30
`define TLS_F_ADJ_IVL  23:0
`define TLS_RST_PDOM   16'h0000
`define TLS_RST_MASK   5'h00
`define TLS_CLK_PS     32'd4000
`define TLS_NS_PER_SEC 31'd1000000000
`endif

// ### hdl/tls_pkg.sv
// Types of the time-of-day load/store unit
package tls_pkg;
  typedef struct packed {
    logic [47:0] sec;
    logic [29:0] nsec;
    logic [31:0] nsf;
  } tls_tod_t;
  typedef enum logic [1:0] {ACT_LOAD, ACT_DELTA, ACT_STORE, ACT_CLOCK} tls_act_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CLK} tls_st_t;
  typedef struct packed {
    logic        in;
    logic        prev;
  } tls_pin_t;
endpackage : tls_pkg

// ### hdl/tls_top.sv
// Time-of-day counters, delta adjusters and load/store controllers
//
// Contract
// - Each time-of-day counter advances nominal period per cycle, adjusted +0/+1/-1.
// - Delta adjuster adds or removes one nanosecond at programmed intervals.
// - Absolute-time setter loads full time into counters on controller command.
// - Five identical load/store controllers.
// - Controller n uses timing pin n; last controller has no pin.
// - Controller registers hold a time set, loaded into or stored from counters.
// - Action selects load, delta add, store, or clock/pulse generation.
// - Store captures seconds, nanoseconds and free-running counter.
// - Seconds 48 bits, nanoseconds 30, free-running 32; free-running never loaded.
// - Sync load/store waits for pin edge, otherwise executes immediately.
// - Clock action with sync gives one pulse at configured time.
// - Inverse polarity detects falling edges and inverts generated waveforms.
// - Waveform-high is clock high time or pulse width in nanoseconds.
// - Waveform-low is clock low time or pulse delay after nanoseconds zero.
// - Delta action adds configured nanoseconds to current time.
// - Each executed operation raises the controller interrupt.
// - Clock action interrupts when the pin turns active.
// - Interrupts individually maskable, status visible to interrupt controller.
// - Three time domains; ports and controllers each select one.
// - All ports default to time domain zero.
`timescale 1ns/1ps
`include "tls_consts.svh"
`default_nettype none
module tls_top #(
  parameter int NCTL  = 5,
  parameter int NPIN  = 4,
  parameter int NDOM  = 3,
  parameter int NPORT = 8
) (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic [11:0]             reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  input  wire logic [NPIN-1:0]         tpin_in,
  output logic      [NPIN-1:0]         tpin_out,
  output logic      [NPIN-1:0]         tpin_oe_n,
  output logic      [NCTL-1:0]         ls_irq,
  output logic      [NCTL-1:0]         ls_irq_status,
  output logic      [2*NPORT-1:0]      port_dom,
  output tls_pkg::tls_tod_t [NDOM-1:0] tod
);
  localparam logic [7:0] NOM_NS = 8'((`TLS_CLK_PS + 32'd999) / 32'd1000);

  tls_pkg::tls_tod_t tod_q [NDOM];
  logic [29:0]       pns_q [NDOM];
  logic [31:0]       adj_q [NDOM];
  logic [23:0]       acnt_q [NDOM];
  logic [7:0]        step [NDOM];
  logic [NDOM-1:0]   adj_hit;
  tls_pkg::tls_act_t act_q [NCTL];
  tls_pkg::tls_st_t  st_q [NCTL];
  logic [NCTL-1:0]   sync_q, inv_q, wave_q, fire, go_hi, edge_det, ctl_wr, wave_end;
  logic [1:0]        dom_q [NCTL];
  logic [47:0]       sec_q [NCTL];
  logic [29:0]       nsec_q [NCTL];
  logic [31:0]       nsf_q [NCTL];
  logic [29:0]       wfh_q [NCTL];
  logic [29:0]       wfl_q [NCTL];
  logic [30:0]       wcnt_q [NCTL];
  logic [NPIN-1:0]   pin_prev_q;
  logic [2*NPORT-1:0] pdom_q;
  logic [NCTL-1:0]   ist_q, imsk_q;
  logic [31:0]       rdata_q;
  logic [NDOM-1:0]   ld_req, dl_req;
  logic [2:0]        ld_src [NDOM];
  logic              ctl_page;
  logic [2:0]        ctl_idx, ctl_reg;

  // Adds nanoseconds to a time, carrying into seconds at the second boundary
  function automatic tls_pkg::tls_tod_t tod_add(tls_pkg::tls_tod_t t, logic [30:0] add);
    logic [30:0] s;
    s = {1'b0, t.nsec} + add;
    tod_add = t;
    if (s >= `TLS_NS_PER_SEC) begin
      s = s - `TLS_NS_PER_SEC;
      tod_add.sec = t.sec + 48'h1;
    end
    tod_add.nsec = s[29:0];
  endfunction : tod_add

  // Active edge on a pin, honouring polarity
  function automatic logic pin_edge(tls_pkg::tls_pin_t p, logic inv);
    pin_edge = inv ? (p.prev & ~p.in) : (p.in & ~p.prev);
  endfunction : pin_edge

  assign ctl_page = reg_addr[11:8] == `TLS_CTL_PAGE;
  assign ctl_idx  = reg_addr[7:5];
  assign ctl_reg  = reg_addr[4:2];

  // Per-domain step and interval adjuster
  always_comb begin
    for (int d = 0; d < NDOM; d++) begin
      adj_hit[d] = adj_q[d][`TLS_F_ADJ_EN] && acnt_q[d] >= adj_q[d][`TLS_F_ADJ_IVL];
      step[d] = NOM_NS;
      if (adj_hit[d]) begin
        step[d] = adj_q[d][`TLS_F_ADJ_DN] ? NOM_NS - 8'h1 : NOM_NS + 8'h1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int d = 0; d < NDOM; d++) begin
        acnt_q[d] <= 24'h0;
      end
    end else begin
      for (int d = 0; d < NDOM; d++) begin
        acnt_q[d] <= adj_hit[d] ? 24'h0 : acnt_q[d] + 24'h1;
      end
    end
  end

  // Controller execution decisions
  always_comb begin
    for (int n = 0; n < NCTL; n++) begin
      ctl_wr[n] = reg_wr && ctl_page && ctl_idx == 3'(n) && ctl_reg == `TLS_R_CTRL;
      edge_det[n] = 1'b0;
      if (n < NPIN) begin
        edge_det[n] = pin_edge({tpin_in[n], pin_prev_q[n]}, inv_q[n]);
      end
      fire[n] = st_q[n] == tls_pkg::ST_WAIT && act_q[n] != tls_pkg::ACT_CLOCK
                && (!sync_q[n] || edge_det[n]);
    end
    for (int d = 0; d < NDOM; d++) begin
      ld_req[d] = 1'b0;
      dl_req[d] = 1'b0;
      ld_src[d] = 3'h0;
      // Lowest-numbered controller wins a same-cycle clash on one domain
      for (int n = NCTL - 1; n >= 0; n--) begin
        if (fire[n] && dom_q[n] == 2'(d) && act_q[n] != tls_pkg::ACT_STORE) begin
          ld_req[d] = act_q[n] == tls_pkg::ACT_LOAD;
          dl_req[d] = act_q[n] == tls_pkg::ACT_DELTA;
          ld_src[d] = 3'(n);
        end
      end
    end
  end

  // Time-of-day counters
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int d = 0; d < NDOM; d++) begin
        tod_q[d] <= '0;
        pns_q[d] <= 30'h0;
      end
    end else begin
      for (int d = 0; d < NDOM; d++) begin
        pns_q[d] <= tod_q[d].nsec;
        if (ld_req[d]) begin
          tod_q[d].sec  <= sec_q[ld_src[d]];
          tod_q[d].nsec <= nsec_q[ld_src[d]];
        end else if (dl_req[d]) begin
          tod_q[d] <= tod_add(tod_q[d], 31'(step[d]) + {1'b0, nsec_q[ld_src[d]]});
        end else begin
          tod_q[d] <= tod_add(tod_q[d], 31'(step[d]));
        end
        // Free-running count is never loaded, so nsf is assigned last
        tod_q[d].nsf <= tod_q[d].nsf + 32'(step[d]);
      end
    end
  end

  // Clock and pulse generation
  always_comb begin
    for (int n = 0; n < NCTL; n++) begin
      go_hi[n] = 1'b0;
      wave_end[n] = st_q[n] == tls_pkg::ST_CLK && wave_q[n]
                    && wcnt_q[n] + 31'(step[dom_q[n]]) >= {1'b0, wfh_q[n]};
      if (st_q[n] == tls_pkg::ST_CLK && !wave_q[n]) begin
        if (sync_q[n]) begin
          go_hi[n] = tod_q[dom_q[n]].nsec >= wfl_q[n] && (pns_q[dom_q[n]] < wfl_q[n]
                     || pns_q[dom_q[n]] > tod_q[dom_q[n]].nsec);
        end else begin
          go_hi[n] = wcnt_q[n] + 31'(step[dom_q[n]]) >= {1'b0, wfl_q[n]};
        end
      end
    end
  end

  // Controller state and registers
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      for (int n = 0; n < NCTL; n++) begin
        st_q[n]   <= tls_pkg::ST_IDLE;
        act_q[n]  <= tls_pkg::ACT_LOAD;
        dom_q[n]  <= 2'h0;
        sec_q[n]  <= 48'h0;
        nsec_q[n] <= 30'h0;
        nsf_q[n]  <= 32'h0;
        wfh_q[n]  <= 30'h0;
        wfl_q[n]  <= 30'h0;
        wcnt_q[n] <= 31'h0;
      end
      sync_q <= '0;
      inv_q  <= '0;
      wave_q <= '0;
    end else begin
      for (int n = 0; n < NCTL; n++) begin
        if (reg_wr && ctl_page && ctl_idx == 3'(n)) begin
          case (ctl_reg)
            `TLS_R_SECH: sec_q[n][47:32] <= reg_wdata[15:0];
            `TLS_R_SECL: sec_q[n][31:0] <= reg_wdata;
            `TLS_R_NSEC: nsec_q[n] <= reg_wdata[29:0];
            `TLS_R_WFH:  wfh_q[n] <= reg_wdata[29:0];
            `TLS_R_WFL:  wfl_q[n] <= reg_wdata[29:0];
            default: ;
          endcase
        end
        if (ctl_wr[n]) begin
          act_q[n]  <= tls_pkg::tls_act_t'(reg_wdata[`TLS_F_ACT]);
          sync_q[n] <= reg_wdata[`TLS_F_SYNC];
          inv_q[n]  <= reg_wdata[`TLS_F_INV];
          dom_q[n]  <= reg_wdata[`TLS_F_DOM];
          wave_q[n] <= 1'b0;
          wcnt_q[n] <= 31'h0;
          if (!reg_wdata[`TLS_F_ARM]) begin
            st_q[n] <= tls_pkg::ST_IDLE;
          end else if (reg_wdata[`TLS_F_ACT] == 2'(tls_pkg::ACT_CLOCK)) begin
            st_q[n] <= tls_pkg::ST_CLK;
          end else begin
            st_q[n] <= tls_pkg::ST_WAIT;
          end
        end else begin
          case (st_q[n])
            tls_pkg::ST_WAIT: begin
              if (fire[n]) begin
                st_q[n] <= tls_pkg::ST_IDLE;
                if (act_q[n] == tls_pkg::ACT_STORE) begin
                  // Capture beats a software write in the same cycle
                  sec_q[n]  <= tod_q[dom_q[n]].sec;
                  nsec_q[n] <= tod_q[dom_q[n]].nsec;
                  nsf_q[n]  <= tod_q[dom_q[n]].nsf;
                end
              end
            end
            tls_pkg::ST_CLK: begin
              if (go_hi[n]) begin
                wave_q[n] <= 1'b1;
                wcnt_q[n] <= 31'h0;
              end else if (wave_end[n]) begin
                wave_q[n] <= 1'b0;
                wcnt_q[n] <= 31'h0;
                if (sync_q[n]) begin
                  st_q[n] <= tls_pkg::ST_IDLE;
                end
              end else begin
                wcnt_q[n] <= wcnt_q[n] + 31'(step[dom_q[n]]);
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // Pins: only the first NPIN controllers have one
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin_prev_q <= '0;
      tpin_out   <= '0;
      tpin_oe_n  <= '1;
    end else begin
      pin_prev_q <= tpin_in;
      for (int p = 0; p < NPIN; p++) begin
        // Pin takes the next waveform level, so high and low last their set times rounded up to whole steps
        tpin_out[p]  <= ((wave_q[p] & ~wave_end[p]) | go_hi[p]) ^ inv_q[p];
        tpin_oe_n[p] <= st_q[p] != tls_pkg::ST_CLK;
      end
    end
  end

  // Interrupt status: set beats write-one-to-clear
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ist_q  <= '0;
      imsk_q <= `TLS_RST_MASK;
    end else begin
      if (reg_wr && reg_addr == `TLS_OFS_IMSK) begin
        imsk_q <= reg_wdata[NCTL-1:0];
      end
      ist_q <= (ist_q & ~((reg_wr && reg_addr == `TLS_OFS_IST) ? reg_wdata[NCTL-1:0] : '0))
               | fire | go_hi;
    end
  end

  assign ls_irq        = ist_q & imsk_q;
  assign ls_irq_status = ist_q;

  // Global configuration
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pdom_q <= `TLS_RST_PDOM;
      for (int d = 0; d < NDOM; d++) begin
        adj_q[d] <= 32'h0;
      end
    end else begin
      if (reg_wr && reg_addr == `TLS_OFS_PDOM) begin
        pdom_q <= reg_wdata[2*NPORT-1:0];
      end
      for (int d = 0; d < NDOM; d++) begin
        if (reg_wr && reg_addr == `TLS_OFS_ADJ0 + 12'(4 * d)) begin
          adj_q[d] <= reg_wdata;
        end
      end
    end
  end

  // Read data, valid the cycle after the strobe
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0;
    end else if (reg_rd) begin
      rdata_q <= 32'h0;
      if (reg_addr == `TLS_OFS_PDOM) begin
        rdata_q <= 32'(pdom_q);
      end else if (reg_addr == `TLS_OFS_IST) begin
        rdata_q <= 32'(ist_q);
      end else if (reg_addr == `TLS_OFS_IMSK) begin
        rdata_q <= 32'(imsk_q);
      end
      for (int d = 0; d < NDOM; d++) begin
        if (reg_addr == `TLS_OFS_ADJ0 + 12'(4 * d)) begin
          rdata_q <= adj_q[d];
        end
      end
      if (ctl_page && ctl_idx < 3'(NCTL)) begin
        case (ctl_reg)
          `TLS_R_CTRL: rdata_q <= {23'h0, st_q[ctl_idx] != tls_pkg::ST_IDLE, 2'h0,
                                   dom_q[ctl_idx], inv_q[ctl_idx], sync_q[ctl_idx],
                                   act_q[ctl_idx]};
          `TLS_R_SECH: rdata_q <= {16'h0, sec_q[ctl_idx][47:32]};
          `TLS_R_SECL: rdata_q <= sec_q[ctl_idx][31:0];
          `TLS_R_NSEC: rdata_q <= {2'h0, nsec_q[ctl_idx]};
          `TLS_R_NSF:  rdata_q <= nsf_q[ctl_idx];
          `TLS_R_WFH:  rdata_q <= {2'h0, wfh_q[ctl_idx]};
          `TLS_R_WFL:  rdata_q <= {2'h0, wfl_q[ctl_idx]};
          default:     rdata_q <= 32'h0;
        endcase
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign port_dom  = pdom_q;
  always_comb begin
    for (int d = 0; d < NDOM; d++) begin
      tod[d] = tod_q[d];
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_nsf_advance: assert property ($past(resetn) |-> (tod_q[0].nsf - $past(tod_q[0].nsf))
    == 32'($past(step[0])) && $past(step[0]) >= NOM_NS - 8'h1 && $past(step[0]) <= NOM_NS + 8'h1)
    else $error("free-running count stepped wrongly");
  a_adj_plus: assert property (adj_hit[2] && !adj_q[2][`TLS_F_ADJ_DN]
    |=> tod_q[2].nsf == $past(tod_q[2].nsf) + 32'(NOM_NS) + 32'h1)
    else $error("adjuster did not add one nanosecond");
  a_load_sec: assert property (fire[0] && act_q[0] == tls_pkg::ACT_LOAD && dom_q[0] == 2'h1
    |=> tod_q[1].sec == $past(sec_q[0]) && tod_q[1].nsec == $past(nsec_q[0]))
    else $error("load did not set the time");
  a_store_cap: assert property (fire[1] && act_q[1] == tls_pkg::ACT_STORE
    |=> nsf_q[1] == $past(tod_q[dom_q[1]].nsf) && sec_q[1] == $past(tod_q[dom_q[1]].sec))
    else $error("store did not capture the time");
  a_imm_start: assert property (ctl_wr[2] && reg_wdata[`TLS_F_ARM] && !reg_wdata[`TLS_F_SYNC]
    && reg_wdata[`TLS_F_ACT] != 2'(tls_pkg::ACT_CLOCK) |=> fire[2] ##1 st_q[2] == tls_pkg::ST_IDLE)
    else $error("immediate operation did not execute");
  a_sync_hold: assert property (st_q[0] == tls_pkg::ST_WAIT && sync_q[0] && !edge_det[0]
    |-> !fire[0]) else $error("synchronized operation ran without pin edge");
  a_irq_exec: assert property (fire[0] |=> ist_q[0] ##0 (imsk_q[0] -> ls_irq[0]))
    else $error("executed operation raised no interrupt");
  a_clk_irq: assert property (go_hi[3] && !ctl_wr[3] |=> wave_q[3] && ist_q[3]
    && tpin_out[3] == !$past(inv_q[3])) else $error("active clock edge raised no interrupt");
  a_last_nopin: assert property (!edge_det[NCTL-1])
    else $error("pinless controller saw an edge");
endmodule : tls_top
`default_nettype wire

// ### dv/tls_pin_eq.sv
// Timing equipment model on the four timing pins
`timescale 1ns/1ps
`default_nettype none
module tls_pin_eq (
  input  wire logic [3:0] pin_lvl,
  input  wire logic [3:0] tpin_out,
  input  wire logic [3:0] tpin_oe_n,
  output logic      [3:0] tpin_in
);
  // Pins taken as already switched to timing use
  // Equipment backs off while the unit drives, so the wire shows the unit
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      tpin_in[i] = tpin_oe_n[i] ? pin_lvl[i] : tpin_out[i];
    end
  end
endmodule : tls_pin_eq
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench of the time-of-day load/store unit
`timescale 1ns/1ps
`include "tls_consts.svh"
`default_nettype none
module tb_top;
  logic                    ref_clk;
  logic                    resetn;
  logic [11:0]             reg_addr;
  logic [31:0]             reg_wdata;
  logic                    reg_wr;
  logic                    reg_rd;
  logic [31:0]             reg_rdata;
  logic [3:0]              pin_lvl;
  logic [3:0]              tpin_in;
  logic [3:0]              tpin_out;
  logic [3:0]              tpin_oe_n;
  logic [4:0]              ls_irq;
  logic [4:0]              ls_irq_status;
  logic [15:0]             port_dom;
  tls_pkg::tls_tod_t [2:0] tod;
  int                      err_count;
  int                      comparisons;
  int                      n;
  int                      k;
  logic [31:0]             rv;
  logic [31:0]             r2;
  logic [31:0]             d0;

  tls_top uut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tpin_in(tpin_in),
    .tpin_out(tpin_out), .tpin_oe_n(tpin_oe_n), .ls_irq(ls_irq),
    .ls_irq_status(ls_irq_status), .port_dom(port_dom), .tod(tod));
  tls_pin_eq peer (.pin_lvl(pin_lvl), .tpin_out(tpin_out), .tpin_oe_n(tpin_oe_n),
    .tpin_in(tpin_in));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [11:0] ca(input int c, input logic [2:0] r);
    return 12'h100 + 12'(c * 32) + {7'h00, r, 2'b00};
  endfunction : ca

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : cyc

  task automatic report_and_stop;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // Bounded wait for a pin level; running out ends the run
  task automatic wait_out(input int i, input logic v);
    // Skip the edge that took the command; the pin still shows the old setup there
    cyc(1);
    n = 0;
    while (tpin_out[i] !== v && n < 300) begin
      cyc(1);
      n++;
    end
    if (n >= 300) begin
      err_count++;
      report_and_stop();
    end
  endtask : wait_out

  // Length of the current run of level v on pin i
  task automatic run_len(input int i, input logic v);
    k = 0;
    while (tpin_out[i] === v && k < 100) begin
      cyc(1);
      k++;
    end
  endtask : run_len

  initial begin
    resetn    = 1'b0;
    reg_addr  = 12'h000;
    reg_wdata = 32'h0000_0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    pin_lvl   = 4'h2;
    err_count = 0;
    comparisons = 0;
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(`TLS_OFS_PDOM, rv);
    chk("pdom reg", 64'h0, {32'h0, rv});
    chk("port_dom", 64'h0, {48'h0, port_dom});
    chk("oe_n", 64'hf, {60'h0, tpin_oe_n});
    rd(`TLS_OFS_IMSK, rv);
    chk("mask", 64'h0, {32'h0, rv});
    rd(12'h0fc, rv);
    chk("unmapped", 64'h0, {32'h0, rv});
    d0 = tod[0].nsf;
    cyc(1);
    chk("step", {32'h0, d0 + 32'd4}, {32'h0, tod[0].nsf});
    wr(`TLS_OFS_PDOM, 32'h0000_2418);
    rd(`TLS_OFS_PDOM, rv);
    chk("pdom wr", 64'h2418, {32'h0, rv});
    chk("port_dom wr", 64'h2418, {48'h0, port_dom});
    // Adjust domain 2 every 4 cycles, domain 0 must not move off nominal
    wr(`TLS_OFS_ADJ0 + 12'h008, 32'h8000_0003);
    cyc(2);
    d0 = tod[2].nsf;
    r2 = tod[0].nsf;
    cyc(8);
    chk("adj up", {32'h0, d0 + 32'd34}, {32'h0, tod[2].nsf});
    chk("adj other", {32'h0, r2 + 32'd32}, {32'h0, tod[0].nsf});
    wr(`TLS_OFS_ADJ0 + 12'h008, 32'hc000_0003);
    cyc(2);
    d0 = tod[2].nsf;
    cyc(8);
    chk("adj down", {32'h0, d0 + 32'd30}, {32'h0, tod[2].nsf});
    wr(`TLS_OFS_ADJ0 + 12'h008, 32'h0000_0000);
    // Immediate load into domain 1
    wr(ca(0, `TLS_R_SECH), 32'h0000_0012);
    wr(ca(0, `TLS_R_SECL), 32'h3456_789a);
    wr(ca(0, `TLS_R_NSEC), 32'd1000);
    wr(ca(0, `TLS_R_CTRL), 32'h0000_0110);
    cyc(3);
    chk("load sec", 64'h0012_3456_789a, {16'h0, tod[1].sec});
    chk("load ns", 64'h1, {63'h0, tod[1].nsec >= 30'd1000 && tod[1].nsec < 30'd1040});
    // Immediate store from domain 1
    wr(ca(1, `TLS_R_CTRL), 32'h0000_0112);
    cyc(3);
    d0 = {2'b00, tod[1].nsec} - tod[1].nsf;
    rd(ca(1, `TLS_R_NSEC), rv);
    rd(ca(1, `TLS_R_NSF), r2);
    chk("store ns", {32'h0, d0}, {32'h0, rv - r2});
    rd(ca(1, `TLS_R_SECL), rv);
    chk("store secl", 64'h3456_789a, {32'h0, rv});
    rd(ca(1, `TLS_R_SECH), rv);
    chk("store sech", 64'h12, {48'h0, rv[15:0]});
    wr(ca(1, `TLS_R_NSF), 32'h0000_0000);
    rd(ca(1, `TLS_R_NSF), rv);
    chk("nsf ro", {32'h0, r2}, {32'h0, rv});
    // Delta add of 100 ns to domain 1
    wr(ca(2, `TLS_R_NSEC), 32'd100);
    d0 = {2'b00, tod[1].nsec} - tod[1].nsf;
    wr(ca(2, `TLS_R_CTRL), 32'h0000_0111);
    cyc(3);
    chk("delta", {32'h0, d0 + 32'd100}, {32'h0, {2'b00, tod[1].nsec} - tod[1].nsf});
    rd(`TLS_OFS_IST, rv);
    chk("status", 64'h7, {32'h0, rv});
    wr(`TLS_OFS_IMSK, 32'h0000_0005);
    cyc(1);
    chk("irq mask", 64'h5, {59'h0, ls_irq});
    wr(`TLS_OFS_IST, 32'h0000_001f);
    cyc(1);
    chk("w1c", 64'h0, {59'h0, ls_irq_status});
    // Pin-synchronised stores: rising on pin 0, falling on pin 1, none for the last
    wr(ca(0, `TLS_R_CTRL), 32'h0000_0106);
    wr(ca(1, `TLS_R_CTRL), 32'h0000_010e);
    wr(ca(4, `TLS_R_CTRL), 32'h0000_0106);
    cyc(10);
    chk("sync idle", 64'h0, {59'h0, ls_irq_status});
    @(posedge ref_clk);
    pin_lvl <= 4'h1;
    cyc(4);
    chk("sync fire", 64'h3, {59'h0, ls_irq_status});
    wr(`TLS_OFS_IST, 32'h0000_001f);
    // Free-running clock, 20 ns high and 40 ns low
    wr(ca(3, `TLS_R_WFH), 32'd20);
    wr(ca(3, `TLS_R_WFL), 32'd40);
    wr(ca(3, `TLS_R_CTRL), 32'h0000_0103);
    wait_out(3, 1'b1);
    chk("clk oe", 64'h0, {63'h0, tpin_oe_n[3]});
    chk("clk irq", 64'h1, {63'h0, ls_irq_status[3]});
    run_len(3, 1'b1);
    chk("clk high", 64'd5, 64'(k));
    run_len(3, 1'b0);
    chk("clk low", 64'd10, 64'(k));
    wr(ca(3, `TLS_R_CTRL), 32'h0000_010b);
    cyc(3);
    chk("inv idle", 64'h1, {63'h0, tpin_out[3]});
    // Single pulse 400 ns ahead on domain 0, 12 ns wide
    rv = {2'b00, tod[0].nsec} + 32'd400;
    wr(ca(3, `TLS_R_WFL), rv);
    wr(ca(3, `TLS_R_WFH), 32'd12);
    wr(ca(3, `TLS_R_CTRL), 32'h0000_0107);
    wait_out(3, 1'b1);
    chk("pulse at", 64'h1, {63'h0, {2'b00, tod[0].nsec} >= rv});
    run_len(3, 1'b1);
    chk("pulse wid", 64'd3, 64'(k));
    cyc(60);
    chk("one pulse", 64'h0, {63'h0, tpin_out[3]});
    wr(ca(3, `TLS_R_CTRL), 32'h0000_0000);
    cyc(2);
    chk("stop oe", 64'h1, {63'h0, tpin_oe_n[3]});
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
